// ===== verilog/hpm_pkg.sv
// constants and types shared by the host pin multiplexer
package hpm_pkg;
  // interface selected by the strap
  typedef enum logic {
    HPM_IF_SPI,
    HPM_IF_I2C
  } hpm_if_e;
  // reset values
  localparam logic HPM_SEL_RST = 1'b0;
  localparam logic [7:0] HPM_IEN_RST = 8'h00;
  localparam logic [7:0] HPM_IOCTL_RST = 8'h00;
  localparam logic [7:0] HPM_IO_RST = 8'h00;
  // field positions
  localparam int HPM_IOCTL_MODEM_BIT = 1;
  localparam int HPM_IO_DSR_BIT = 4;
  localparam int HPM_IO_DTR_BIT = 5;
  // number of programmable pins and interrupt sources
  localparam int HPM_IO_W = 6;
  localparam int HPM_SRC_W = 5;
  // interrupt source positions
  localparam int HPM_SRC_PIN = 0;
  localparam int HPM_SRC_RXERR = 1;
  localparam int HPM_SRC_RXDATA = 2;
  localparam int HPM_SRC_TXSPACE = 3;
  localparam int HPM_SRC_MODEM = 4;
  // synchroniser depth
  localparam int HPM_SYNC_STAGES = 2;
endpackage

// ===== verilog/hpm_sync.sv
// two flip-flop level synchroniser, one bit per lane
`timescale 1ns/1ns
module hpm_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // async in, synchronised out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta; // first stage, read only by q
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  // next values
  always_comb begin
    next_meta = srst ? '0 : d;
    next_q = srst ? '0 : meta;
  end

  // registers
  always_ff @(posedge clk) begin
    meta <= next_meta;
    q <= next_q;
  end
endmodule

// ===== verilog/hpm_link.sv
// link-side capture of the host serial pins on the host serial clock
`timescale 1ns/1ns
module hpm_link (
  // link clock and reset
  input wire logic link_clk,
  input wire logic link_rst,
  // decoded selection, already synchronised
  input wire logic spi_sel,
  // data pin from host
  input wire logic data_in,
  // captured bit shift register and toggle per bit
  output logic [7:0] shift,
  output logic bit_tgl
);
  logic [7:0] next_shift;
  logic next_bit_tgl;

  // shift one bit per rising link clock while selected
  always_comb begin
    next_shift = shift;
    next_bit_tgl = bit_tgl;
    if (link_rst) begin
      next_shift = 8'h00;
      next_bit_tgl = 1'b0;
    end else if (spi_sel) begin
      next_shift = {shift[6:0], data_in};
      next_bit_tgl = ~bit_tgl;
    end
  end

  // registers
  always_ff @(posedge link_clk) begin
    shift <= next_shift;
    bit_tgl <= next_bit_tgl;
  end
endmodule

// ===== verilog/hpm_top.sv
// host interface pin multiplexer: strap, shared pins, interrupt and dual-use io
`timescale 1ns/1ns
module hpm_top (
  // system clock and reset
  input wire logic clk,
  input wire logic srst,
  // host serial clock, second domain
  input wire logic host_sclk,
  // strap
  input wire logic iface_sel,
  // shared host pins
  input wire logic chip_select_or_addr_sel_lo,
  input wire logic serial_in_or_addr_sel_hi,
  output logic serial_out,
  output logic serial_out_oe,
  input wire logic i2c_data_i,
  output logic i2c_data_o,
  output logic i2c_data_oe,
  // core side: data to place on the host line
  input wire logic core_tx_bit,
  input wire logic core_tx_en,
  // core side: decoded host state
  output logic spi_mode,
  output logic [1:0] addr_sel,
  output logic chip_sel,
  output logic [7:0] rx_shift,
  output logic rx_bit_pulse,
  // interrupt
  input wire logic [7:0] interrupt_enable_reg,
  input wire logic [4:0] irq_src,
  output logic irq_n_o,
  output logic irq_n_oe,
  // programmable io and modem pins
  input wire logic [7:0] io_function_control_reg,
  input wire logic [5:0] io_dir,
  input wire logic [5:0] io_out,
  input wire logic [5:0] io_pin_i,
  output logic [5:0] io_pin_o,
  output logic [5:0] io_pin_oe,
  output logic [5:0] io_in,
  input wire logic terminal_ready,
  output logic data_set_ready
);
  // synchronised pin levels
  logic sel_s; // strap
  logic cs_act_s; // chip select active (pin inverted); address lo inverted
  logic a1_s; // address hi
  logic [5:0] io_s; // io pins
  logic tgl_s; // bit toggle from link domain
  logic tgl_d; // previous toggle
  logic [7:0] shift_s; // link shift register copy, never driven or read
  logic [7:0] link_shift;
  logic link_tgl;
  logic link_sel_s; // chip select seen in link domain
  logic link_rst_s; // reset seen in link domain
  logic spi_active; // spi and selected, carried into the link domain

  // next values
  logic next_spi_mode;
  logic [1:0] next_addr_sel;
  logic next_chip_sel;
  logic next_serial_out;
  logic next_serial_out_oe;
  logic next_i2c_data_o;
  logic next_i2c_data_oe;
  logic next_irq_n_o;
  logic next_irq_n_oe;
  logic [5:0] next_io_pin_o;
  logic [5:0] next_io_pin_oe;
  logic [5:0] next_io_in;
  logic next_data_set_ready;
  logic next_tgl_d;
  logic [7:0] next_rx_shift;
  logic next_rx_bit_pulse;
  logic modem;
  logic pend;

  // pin synchronisers into clk
  hpm_sync #(.W(9)) u_sync (
    .clk(clk),
    .srst(srst),
    // select lane inverted so its reset level means deselected: no false select
    .d({iface_sel, ~chip_select_or_addr_sel_lo, serial_in_or_addr_sel_hi, io_pin_i}),
    .q({sel_s, cs_act_s, a1_s, io_s})
  );

  // toggle from link domain into clk
  hpm_sync #(.W(1)) u_sync_tgl (
    .clk(clk),
    .srst(srst),
    .d(link_tgl),
    .q(tgl_s)
  );

  // select and reset carried into the link domain
  assign spi_active = spi_mode & chip_sel;
  hpm_sync #(.W(2)) u_sync_link (
    .clk(host_sclk),
    .srst(1'b0),
    .d({spi_active, srst}),
    .q({link_sel_s, link_rst_s})
  );

  // link capture on the host clock, spi only
  hpm_link u_link (
    .link_clk(host_sclk),
    .link_rst(link_rst_s),
    .spi_sel(link_sel_s),
    .data_in(serial_in_or_addr_sel_hi),
    .shift(link_shift),
    .bit_tgl(link_tgl)
  );

  assign modem = io_function_control_reg[hpm_pkg::HPM_IOCTL_MODEM_BIT];
  assign pend = |(irq_src & interrupt_enable_reg[4:0]);

  // host pin decode
  always_comb begin
    next_spi_mode = (sel_s == hpm_pkg::HPM_IF_SPI);
    next_chip_sel = next_spi_mode & cs_act_s;
    next_addr_sel = next_spi_mode ? 2'h0 : {a1_s, ~cs_act_s};
    // spi output drives only while selected
    next_serial_out = core_tx_bit;
    next_serial_out_oe = next_chip_sel & core_tx_en;
    // i2c data pulls low only, never driven in spi
    next_i2c_data_o = 1'b0;
    next_i2c_data_oe = ~next_spi_mode & core_tx_en & ~core_tx_bit;
    // interrupt: pull low when enabled source pending
    next_irq_n_o = 1'b0; // pin only ever pulls low
    next_irq_n_oe = pend;
    // bit activity seen through the toggle; lossy when the host clock outruns clk
    next_tgl_d = tgl_s;
    next_rx_bit_pulse = tgl_s ^ tgl_d;
    next_rx_shift = rx_shift;
    // word taken at frame end: the host clock idles once deselected, so the
    // link word has stood still for the whole select synchroniser delay
    if (chip_sel & ~next_chip_sel) begin
      next_rx_shift = link_shift;
    end
    // programmable io
    next_io_pin_o = io_out;
    next_io_pin_oe = io_dir;
    next_io_in = io_s;
    next_data_set_ready = 1'b0;
    if (modem) begin
      next_io_pin_oe[hpm_pkg::HPM_IO_DSR_BIT] = 1'b0;
      next_data_set_ready = ~io_s[hpm_pkg::HPM_IO_DSR_BIT];
      next_io_pin_oe[hpm_pkg::HPM_IO_DTR_BIT] = 1'b1;
      next_io_pin_o[hpm_pkg::HPM_IO_DTR_BIT] = ~terminal_ready;
    end
    if (srst) begin
      next_spi_mode = 1'b1;
      next_chip_sel = 1'b0;
      next_addr_sel = 2'h0;
      next_serial_out = 1'b0;
      next_serial_out_oe = 1'b0;
      next_i2c_data_oe = 1'b0;
      next_irq_n_oe = 1'b0;
      next_tgl_d = 1'b0;
      next_rx_bit_pulse = 1'b0;
      next_rx_shift = 8'h00;
      next_io_pin_o = 6'h00;
      next_io_pin_oe = 6'h00;
      next_io_in = 6'h00;
      next_data_set_ready = 1'b0;
    end
  end

  // registers
  always_ff @(posedge clk) begin
    spi_mode <= next_spi_mode;
    chip_sel <= next_chip_sel;
    addr_sel <= next_addr_sel;
    serial_out <= next_serial_out;
    serial_out_oe <= next_serial_out_oe;
    i2c_data_o <= next_i2c_data_o;
    i2c_data_oe <= next_i2c_data_oe;
    irq_n_o <= next_irq_n_o;
    irq_n_oe <= next_irq_n_oe;
    tgl_d <= next_tgl_d;
    rx_bit_pulse <= next_rx_bit_pulse;
    rx_shift <= next_rx_shift;
    io_pin_o <= next_io_pin_o;
    io_pin_oe <= next_io_pin_oe;
    io_in <= next_io_in;
    data_set_ready <= next_data_set_ready;
  end

  // interrupt follows enabled pending sources one cycle later
  irq_follow_a: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) |-> irq_n_oe == $past(pend)) else $error("irq enable wrong");
  irq_release_a: assert property (@(posedge clk) disable iff (srst)
    $past(interrupt_enable_reg[4:0]) == 5'h00 |-> !irq_n_oe)
    else $error("irq driven while disabled");
  spi_out_a: assert property (@(posedge clk) disable iff (srst)
    serial_out_oe |-> chip_sel && spi_mode) else $error("so driven unselected");
  i2c_dat_a: assert property (@(posedge clk) disable iff (srst)
    i2c_data_oe |-> !spi_mode && !i2c_data_o) else $error("sda misdriven");
  addr_zero_a: assert property (@(posedge clk) disable iff (srst)
    spi_mode |-> addr_sel == 2'h0) else $error("addr in spi");
  cs_mode_a: assert property (@(posedge clk) disable iff (srst)
    chip_sel |-> spi_mode) else $error("cs in i2c");
  dtr_drive_a: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) && $past(modem) |-> io_pin_oe[5] && io_pin_o[5] == !$past(terminal_ready))
    else $error("dtr pin wrong");
  dsr_input_a: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) && $past(modem) |-> !io_pin_oe[4]) else $error("dsr pin driven");
  io_plain_a: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) && !$past(modem) |-> io_pin_oe == $past(io_dir))
    else $error("io dir wrong");
  // frame end hands the link word over unchanged
  rx_take_a: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) && $past(chip_sel) && !chip_sel |-> rx_shift == $past(link_shift))
    else $error("rx word not taken");
  // spi output carries the core bit of the previous cycle
  so_value_a: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) && serial_out_oe |-> serial_out == $past(core_tx_bit))
    else $error("so bit wrong");
  // strap level decides the mode, low picks spi
  mode_strap_a: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) |-> spi_mode == !$past(sel_s)) else $error("mode wrong");
  // data line left alone while spi is picked
  sda_quiet_a: assert property (@(posedge clk) disable iff (srst)
    spi_mode |-> !i2c_data_oe) else $error("sda driven in spi");
endmodule

// ===== test/hpm_host.sv
// host controller model: serial clock, select and data toward the device
`timescale 1ns/1ns
module hpm_host (
  // host pins
  output logic host_sclk,
  output logic cs_n,
  output logic sdi
);
  initial begin
    host_sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // a few clock pulses: deselected in reset to clear the link domain, selected per bit in spi_byte
  task automatic pulses(input int n);
    repeat (n) begin
      #3 host_sclk = 1'b1;
      #3 host_sclk = 1'b0;
    end
  endtask
  // one byte msb first, two lead bits let the link sync settle
  task automatic spi_byte(input logic [7:0] b);
    cs_n = 1'b0;
    #40;
    for (int i = 9; i >= 0; i--) begin
      sdi = (i > 7) ? 1'b0 : b[i];
      pulses(1);
    end
    // released data line, no pull: show the inverse
    sdi = ~sdi;
    #20 cs_n = 1'b1;
  endtask
endmodule

// ===== test/test_hpm_top.sv
// self-checking bench for the host pin multiplexer
`timescale 1ns/1ns
module test_hpm_top;
  // clock, reset, strap and core side
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic iface_sel = 1'b0;
  logic [1:0] addr = 2'h0;
  logic core_tx_bit = 1'b0;
  logic core_tx_en = 1'b0;
  logic [7:0] interrupt_enable_reg = 8'h00;
  logic [4:0] irq_src = 5'h00;
  logic [7:0] io_function_control_reg = 8'h00;
  logic [5:0] io_dir = 6'h00;
  logic [5:0] io_out = 6'h00;
  logic [5:0] io_ext = 6'h00;
  logic terminal_ready = 1'b0;
  // design outputs
  logic serial_out, serial_out_oe, i2c_data_o, i2c_data_oe, spi_mode, chip_sel;
  logic [1:0] addr_sel;
  logic [7:0] rx_shift;
  logic rx_bit_pulse, irq_n_o, irq_n_oe, data_set_ready;
  logic [5:0] io_pin_o, io_pin_oe, io_in;
  // pin levels: shared pins, open-drain lines with pull-ups
  wire host_sclk, cs_n, sdi;
  wire pin_lo = iface_sel ? addr[0] : cs_n;
  wire pin_hi = iface_sel ? addr[1] : sdi;
  wire i2c_data_i = i2c_data_oe ? i2c_data_o : 1'b1;
  wire irq_line = irq_n_oe ? irq_n_o : 1'b1;
  wire [5:0] io_pin_i = (io_pin_oe & io_pin_o) | (~io_pin_oe & io_ext);
  int fails = 0;
  int comparisons = 0;
  logic [7:0] b;
  logic m;
  logic [5:0] exp_in;
  int bit_pulses = 0;
  int pulse_base;
  hpm_host host (.host_sclk, .cs_n, .sdi);
  hpm_top dut (.clk, .srst, .host_sclk, .iface_sel, .chip_select_or_addr_sel_lo(pin_lo),
    .serial_in_or_addr_sel_hi(pin_hi), .serial_out, .serial_out_oe, .i2c_data_i, .i2c_data_o,
    .i2c_data_oe, .core_tx_bit, .core_tx_en, .spi_mode, .addr_sel, .chip_sel, .rx_shift,
    .rx_bit_pulse, .interrupt_enable_reg, .irq_src, .irq_n_o, .irq_n_oe,
    .io_function_control_reg, .io_dir, .io_out, .io_pin_i, .io_pin_o, .io_pin_oe, .io_in,
    .terminal_ready, .data_set_ready);
  always #4 clk = ~clk;
  // count bit activity pulses, sampled away from the launching edge
  always @(negedge clk) begin
    if (rx_bit_pulse === 1'b1) begin
      bit_pulses++;
    end
  end
  // compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic final_report();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // reset with link clock pulses so the link domain clears too
  task automatic do_reset(input logic sel);
    srst = 1'b1;
    iface_sel = sel;
    fork
      host.pulses(4);
    join_none
    step(5);
    srst = 1'b0;
    step(4);
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    final_report();
  end
  initial begin
    void'($urandom(10919));
    do_reset(1'b0);
    check("spi_mode", spi_mode, 1'b1);
    check("addr_sel", addr_sel, 2'h0);
    check("sda_oe", i2c_data_oe, 1'b0);
    core_tx_en = 1'b1;
    // spi bytes: select, data out while selected, capture on serial clock
    repeat (3) begin
      b = 8'($urandom);
      core_tx_bit = 1'($urandom);
      pulse_base = bit_pulses;
      fork
        host.spi_byte(b);
        begin
          step(6);
          check("chip_sel", chip_sel, 1'b1);
          check("so_oe", serial_out_oe, 1'b1);
          check("so", serial_out, core_tx_bit);
        end
      join
      step(6);
      check("rx_shift", rx_shift, b);
      check("chip_sel_off", chip_sel, 1'b0);
      check("bit_pulse", 8'(bit_pulses > pulse_base), 8'h01);
    end
    do_reset(1'b1);
    check("i2c_mode", spi_mode, 1'b0);
    for (int a = 0; a < 4; a++) begin
      addr = 2'(a);
      step(4);
      check("addr_sel", addr_sel, addr);
    end
    // open-drain data: low only for a zero bit, data out never driven
    for (int t = 0; t < 2; t++) begin
      core_tx_bit = 1'(t);
      step(4);
      check("sda_line", i2c_data_i, 8'(t));
      check("so_oe_i2c", serial_out_oe, 1'b0);
    end
    // each source alone enabled and masked, then random mixes
    for (int j = 0; j < 30; j++) begin
      irq_src = (j < 10) ? (5'h01 << (j / 2)) : 5'($urandom);
      interrupt_enable_reg = (j < 10) ?
        ((j % 2) ? (8'($urandom) & ~{3'h0, irq_src}) : {3'h0, irq_src}) : 8'($urandom);
      step(2);
      check("irq_line", irq_line, !(|(interrupt_enable_reg[4:0] & irq_src)));
    end
    // programmable io and modem use
    repeat (12) begin
      io_function_control_reg = 8'($urandom);
      m = io_function_control_reg[1];
      io_dir = 6'($urandom);
      io_out = 6'($urandom);
      io_ext = 6'($urandom) | (m ? 6'h20 : 6'h00);
      terminal_ready = 1'($urandom);
      exp_in = (io_dir & io_out) | (~io_dir & io_ext);
      step(5);
      check("io_oe", io_pin_oe[3:0], io_dir[3:0]);
      check("io_in", io_in[3:0], exp_in[3:0]);
      if (m) begin
        check("dsr", data_set_ready, !io_ext[4]);
        check("dtr_line", io_pin_i[5], !terminal_ready);
        check("dtr_oe", io_pin_oe[5:4], 2'h2);
        check("dtr_o", io_pin_o[5], !terminal_ready);
      end else begin
        check("io5_oe", io_pin_oe[5:4], io_dir[5:4]);
        check("io_hi_in", io_in[5:4], exp_in[5:4]);
        check("dsr_off", data_set_ready, 1'b0);
      end
    end
    final_report();
  end
endmodule
